// *** ufc_pkg.sv ***
/*
  shared constants for the uart flow control feature block:
  register byte offsets, field positions and reset values.
  assumes an apb master with 32-bit data, one register per word.
*/
package ufc_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_FEATURE  = 8'h00;
  localparam logic [7:0] OFS_ENHANCED = 8'h04;
  localparam logic [7:0] OFS_SCRATCH  = 8'h08;
  localparam logic [7:0] OFS_INT_EN   = 8'h0C;
  localparam logic [7:0] OFS_FIFO_CTL = 8'h10;
  localparam logic [7:0] OFS_MODEM    = 8'h14;
  localparam logic [7:0] OFS_INT_STAT = 8'h18;
  localparam logic [7:0] OFS_RESUME1  = 8'h1C;
  localparam logic [7:0] OFS_RESUME2  = 8'h20;
  localparam logic [7:0] OFS_STOP1    = 8'h24;
  localparam logic [7:0] OFS_STOP2    = 8'h28;
  localparam logic [7:0] OFS_TRIGGER  = 8'h2C;
  localparam logic [7:0] OFS_COUNT    = 8'h30;
  // reset values
  localparam logic [7:0] RST_ZERO    = 8'h00;
  localparam logic [7:0] RST_SCRATCH = 8'hFF;
  localparam logic [7:0] RST_MODE    = 8'h80;
  // feature_control fields
  localparam int FC_DIR_EN  = 3;
  localparam int FC_TBL_LO  = 4;
  localparam int FC_SWAP    = 6;
  localparam int FC_TRG_SEL = 7;
  // enhanced_feature fields
  localparam int EF_ENH     = 4;
  localparam int EF_SPECIAL = 5;
  localparam int EF_ARTS    = 6;
  localparam int EF_ACTS    = 7;
  // enhanced_mode_select fields
  localparam int EM_DIR_INV = 3;
  // modem_control and interrupt_enable fields
  localparam int MC_RTS     = 1;
  localparam int IE_SPECIAL = 5;
  // two-bit flow control select codes
  localparam logic [1:0] FLOW_NONE   = 2'b00;
  localparam logic [1:0] FLOW_FIRST  = 2'b10;
  localparam logic [1:0] FLOW_SECOND = 2'b01;
  localparam logic [1:0] FLOW_BOTH   = 2'b11;
  // count select codes in enhanced_mode_select[1:0]
  localparam logic [1:0] CNT_ALT = 2'b11;
  typedef enum logic [1:0] {DIR_IDLE, DIR_SEND, DIR_TAIL} ufc_dir_e;
endpackage

// *** ufc_features.sv ***
/*
  flow control and enhanced feature logic of one uart channel.
  assumes the uart core on the same clock gives fifo levels, a bit
  tick, shifter status and received characters; cts_n is a pin.
*/
// The placing of the registers and the APB interface to the registers were left to the implementer.
// What this block does
// - legacy mode: tx interrupt on holding empty
// - rts rises one bit after last stop
// - direction mode: tx interrupt waits for shifter
// - fifo write drops rts in direction mode
// - polarity bit inverts direction rts levels
// - two bits pick trigger table a-d
// - swap clear: scratchpad is plain storage
// - swap set: read count, write mode
// - select bit steers trigger/count rx or tx
// - upper select bits pick tx flow characters
// - lower select bits pick rx comparison
// - dual mode: either pair, or pair as two sequential characters when tx select is none or both
// - enhanced bits writable only when enabled
// - reset clears all gated enhanced bits
// - special match stored outside second-pair mode, status bit set
// - second-pair mode swallows stop, raises interrupts
// - auto rts interrupt and hysteresis levels
// - auto rts only after software asserts rts
// - no flow control: rts is software output
// - auto cts halts transmit while cts high
// - alternate mode reads rx then tx count
`timescale 1ns/1ps
module ufc_features
  import ufc_pkg::*;
#(
  parameter int CNT_W = 7
)(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             thr_empty,
  input  wire logic             tsr_empty,
  input  wire logic             tx_fifo_write,
  input  wire logic             bit_tick,
  input  wire logic [CNT_W-1:0] rx_count,
  input  wire logic [CNT_W-1:0] tx_count,
  input  wire logic             rx_at_trigger,
  input  wire logic             rx_above_upper,
  input  wire logic             rx_below_lower,
  input  wire logic             rx_valid,
  input  wire logic [7:0]       rx_char,
  input  wire logic             cts_n,
  output logic                  rts_n,
  output logic                  tx_int,
  output logic                  tx_go,
  output logic                  rx_store,
  output logic                  rx_resume,
  output logic                  rx_stop,
  output logic                  special_int,
  output logic                  rx_trig_int,
  output logic [1:0]            table_sel,
  output logic [1:0]            tx_flow_sel,
  output logic [7:0]            rx_trigger_level,
  output logic [7:0]            tx_trigger_level
);
  logic [7:0] feat_reg, enh_reg, spr_reg, mode_reg;
  logic [7:0] ier_reg, fcr_reg, mcr_reg;
  logic [1:0] isr_reg;
  logic [7:0] res1_reg, res2_reg, stop1_reg, stop2_reg;
  logic [7:0] rx_trg_reg, tx_trg_reg;
  logic       alt_tx_reg, flow_hold_reg, go_reg, rts_reg;
  logic       cts_m_reg, cts_s_reg, seq_res_reg, seq_stop_reg;
  logic       wr, rd, enh, swap, rx_next, rts_next;
  logic [1:0] rx_mode, tx_mode;
  logic [7:0] cnt_sel, rdata;
  logic       m_r1, m_r2, m_s1, m_s2, special_hit, swallow;
  ufc_dir_e   dir_reg, dir_next;

  // apb access phase strobes
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign enh = enh_reg[EF_ENH];
  assign swap = feat_reg[FC_SWAP];
  assign rx_mode = enh_reg[1:0];
  assign tx_mode = enh_reg[3:2];

  // plain feature registers and flow characters
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      feat_reg  <= RST_ZERO;
      enh_reg   <= RST_ZERO;
      res1_reg  <= RST_ZERO;
      res2_reg  <= RST_ZERO;
      stop1_reg <= RST_ZERO;
      stop2_reg <= RST_ZERO;
    end
    else if (wr)
    begin
      if (paddr == OFS_FEATURE) feat_reg <= pwdata[7:0];
      else if (paddr == OFS_ENHANCED) enh_reg <= pwdata[7:0];
      else if (paddr == OFS_RESUME1) res1_reg <= pwdata[7:0];
      else if (paddr == OFS_RESUME2) res2_reg <= pwdata[7:0];
      else if (paddr == OFS_STOP1) stop1_reg <= pwdata[7:0];
      else if (paddr == OFS_STOP2) stop2_reg <= pwdata[7:0];
    end

  // scratchpad and mode select share one location
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      spr_reg  <= RST_SCRATCH;
      mode_reg <= RST_MODE;
    end
    else if (wr && paddr == OFS_SCRATCH)
    begin
      if (swap) mode_reg <= pwdata[7:0];
      else spr_reg <= pwdata[7:0];
    end

  // write-gated enhanced bits, all other bits always writable
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ier_reg <= RST_ZERO;
      fcr_reg <= RST_ZERO;
      mcr_reg <= RST_ZERO;
    end
    else if (wr)
    begin
      if (paddr == OFS_INT_EN)
        ier_reg <= {enh ? pwdata[7:4] : ier_reg[7:4], pwdata[3:0]};
      else if (paddr == OFS_FIFO_CTL)
        fcr_reg <= {pwdata[7:6], enh ? pwdata[5:4] : fcr_reg[5:4],
                    pwdata[3:0]};
      else if (paddr == OFS_MODEM)
        mcr_reg <= {enh ? pwdata[7:5] : mcr_reg[7:5], pwdata[4:0]};
    end

  // status bits 5:4; hardware detection wins over a write
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) isr_reg <= 2'b00;
    else
    begin
      if (wr && paddr == OFS_INT_STAT && enh) isr_reg <= pwdata[5:4];
      // special match sets status bit 4
      if (special_hit) isr_reg[0] <= 1'b1;
    end

  // trigger level program, steered by select bit
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      rx_trg_reg <= RST_ZERO;
      tx_trg_reg <= RST_ZERO;
    end
    // select bit picks rx or tx
    else if (wr && paddr == OFS_TRIGGER)
    begin
      if (feat_reg[FC_TRG_SEL]) tx_trg_reg <= pwdata[7:0];
      else rx_trg_reg <= pwdata[7:0];
    end

  // alternate count: restart at rx on mode write, flip per read
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) alt_tx_reg <= 1'b0;
    else if (wr && paddr == OFS_SCRATCH && swap) alt_tx_reg <= 1'b0;
    else if (rd && paddr == OFS_SCRATCH && swap
             && mode_reg[1:0] == CNT_ALT)
      alt_tx_reg <= !alt_tx_reg;

  // count shown through the swapped scratchpad
  always_comb
  begin
    cnt_sel = 8'(rx_count);
    if (mode_reg[1:0] == CNT_ALT)
    begin
      if (alt_tx_reg) cnt_sel = 8'(tx_count);
    end
    else if (mode_reg[0]) cnt_sel = 8'(tx_count);
  end

  // read decode; unmapped answers zero with an error
  always_comb
  begin
    rdata = RST_ZERO;
    pslverr = 1'b0;
    if (paddr == OFS_FEATURE) rdata = feat_reg;
    else if (paddr == OFS_ENHANCED) rdata = enh_reg;
    else if (paddr == OFS_SCRATCH) rdata = swap ? cnt_sel : spr_reg;
    else if (paddr == OFS_INT_EN) rdata = ier_reg;
    else if (paddr == OFS_FIFO_CTL) rdata = fcr_reg;
    else if (paddr == OFS_MODEM) rdata = mcr_reg;
    else if (paddr == OFS_INT_STAT) rdata = {2'b00, isr_reg, 4'h0};
    else if (paddr == OFS_RESUME1) rdata = res1_reg;
    else if (paddr == OFS_RESUME2) rdata = res2_reg;
    else if (paddr == OFS_STOP1) rdata = stop1_reg;
    else if (paddr == OFS_STOP2) rdata = stop2_reg;
    else if (paddr == OFS_TRIGGER)
      rdata = feat_reg[FC_TRG_SEL] ? tx_trg_reg : rx_trg_reg;
    else if (paddr == OFS_COUNT)
      rdata = feat_reg[FC_TRG_SEL] ? 8'(tx_count) : 8'(rx_count);
    else pslverr = psel;
    prdata = {24'h00_0000, rdata};
  end

  // table select passed to trigger logic
  assign table_sel = feat_reg[FC_TBL_LO+1:FC_TBL_LO];
  assign rx_trigger_level = rx_trg_reg;
  assign tx_trigger_level = tx_trg_reg;
  assign tx_flow_sel = tx_mode;

  // receive compare against flow characters
  assign m_r1 = rx_char == res1_reg;
  assign m_r2 = rx_char == res2_reg;
  assign m_s1 = rx_char == stop1_reg;
  assign m_s2 = rx_char == stop2_reg;
  assign special_hit = rx_valid && enh_reg[EF_SPECIAL] && m_s2;
  // second-pair mode keeps stop out of fifo
  assign swallow = special_hit && rx_mode == FLOW_SECOND;
  assign rx_store = rx_valid && !swallow;
  assign special_int = special_hit
                       && (rx_mode != FLOW_SECOND || ier_reg[IE_SPECIAL]);

  // resume and stop detection per receive mode
  always_comb
  begin
    rx_resume = 1'b0;
    rx_stop = 1'b0;
    case (rx_mode)
      FLOW_FIRST:
      begin
        rx_resume = rx_valid && m_r1;
        rx_stop = rx_valid && m_s1;
      end
      FLOW_SECOND:
      begin
        rx_resume = rx_valid && m_r2;
        rx_stop = rx_valid && m_s2;
      end
      FLOW_BOTH:
        // either pair, or pair as sequence
        if (tx_mode == FLOW_FIRST || tx_mode == FLOW_SECOND)
        begin
          rx_resume = rx_valid && (m_r1 || m_r2);
          rx_stop = rx_valid && (m_s1 || m_s2);
        end
        else
        begin
          rx_resume = rx_valid && seq_res_reg && m_r2;
          rx_stop = rx_valid && seq_stop_reg && m_s2;
        end
      default: ;
    endcase
  end

  // remembers a first-of-pair match for sequence mode
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      seq_res_reg <= 1'b0;
      seq_stop_reg <= 1'b0;
    end
    else if (rx_valid)
    begin
      seq_res_reg <= m_r1;
      seq_stop_reg <= m_s1;
    end

  // cts pin synchroniser
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cts_m_reg <= 1'b1;
      cts_s_reg <= 1'b1;
    end
    else
    begin
      cts_m_reg <= cts_n;
      cts_s_reg <= cts_m_reg;
    end

  // transmit permission, changed only between characters
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) go_reg <= 1'b1;
    else if (tsr_empty)
      // cts high halts the next start
      go_reg <= !(enh_reg[EF_ACTS] && cts_s_reg);
  assign tx_go = go_reg;

  // transmit interrupt source
  // direction mode waits for shifter
  assign tx_int = thr_empty && (!feat_reg[FC_DIR_EN] || tsr_empty);

  // direction control sequence
  always_comb
  begin
    dir_next = dir_reg;
    case (dir_reg)
      DIR_IDLE: if (tx_fifo_write) dir_next = DIR_SEND;
      DIR_SEND:
        if (thr_empty && tsr_empty && !tx_fifo_write)
          dir_next = DIR_TAIL;
      DIR_TAIL:
        if (tx_fifo_write) dir_next = DIR_SEND;
        // one bit time after last stop
        else if (bit_tick) dir_next = DIR_IDLE;
      default: dir_next = DIR_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) dir_reg <= DIR_IDLE;
    else dir_reg <= dir_next;

  // auto rts: hold high above upper, release below lower
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) flow_hold_reg <= 1'b0;
    else if (rx_above_upper) flow_hold_reg <= 1'b1;
    else if (rx_below_lower) flow_hold_reg <= 1'b0;
  assign rx_trig_int = enh_reg[EF_ARTS] && rx_at_trigger;

  // rts pin source selection
  always_comb
  begin
    // software level when no flow control
    rts_next = !mcr_reg[MC_RTS];
    if (feat_reg[FC_DIR_EN])
      rts_next = (dir_next == DIR_IDLE) ^ mode_reg[EM_DIR_INV];
    // auto rts only once software asserts
    else if (enh_reg[EF_ARTS] && mcr_reg[MC_RTS])
      rts_next = flow_hold_reg;
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) rts_reg <= 1'b1;
    else rts_reg <= rts_next;
  assign rts_n = rts_reg;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_TXINT_LEGACY: assert property (
    !feat_reg[FC_DIR_EN] && thr_empty |-> tx_int)
    else $error("tx interrupt missing in legacy mode");
  AST_TXINT_HOLD: assert property (
    feat_reg[FC_DIR_EN] && !tsr_empty |-> !tx_int)
    else $error("tx interrupt before shifter empty");
  AST_DIR_DROP: assert property (
    feat_reg[FC_DIR_EN] && tx_fifo_write && $stable(feat_reg)
    && $stable(mode_reg) |=> rts_n == mode_reg[EM_DIR_INV])
    else $error("rts not driven active on fifo write");
  AST_DIR_TAIL: assert property (
    dir_reg == DIR_TAIL && bit_tick && !tx_fifo_write
    && feat_reg[FC_DIR_EN] ##1 $stable(mode_reg)
    |-> rts_n != mode_reg[EM_DIR_INV])
    else $error("rts not released after tail bit");
  AST_GATE: assert property (
    !enh |=> $stable(ier_reg[7:4]) && $stable(mcr_reg[7:5]))
    else $error("gated bit changed while locked");
  AST_SWALLOW: assert property (
    swallow |-> !rx_store ##1 isr_reg[0])
    else $error("second stop entered fifo");
  AST_CTS: assert property (
    enh_reg[EF_ACTS] && cts_s_reg && tsr_empty |=> !tx_go)
    else $error("transmit allowed with cts high");
  AST_CTS_FRAME: assert property (
    !tsr_empty && !$past(tsr_empty) |-> $stable(tx_go))
    else $error("tx permission changed mid character");
  AST_RTS_SW: assert property (
    !feat_reg[FC_DIR_EN] && !enh_reg[EF_ARTS]
    |=> rts_n == !$past(mcr_reg[MC_RTS]))
    else $error("rts not following software bit");

  COV_DIR: cover property (dir_reg == DIR_TAIL ##1 dir_reg == DIR_IDLE);
  COV_SWAP: cover property (rd && paddr == OFS_SCRATCH && alt_tx_reg);
  COV_HOLD: cover property (enh_reg[EF_ARTS] && flow_hold_reg);
  COV_SEQ: cover property (rx_stop && rx_mode == FLOW_BOTH);
endmodule

// *** ufc_remote.sv ***
/*
  far side of the uart: baud tick, received characters and the cts pin.
  assumes the bench drives cts_hold at a rising edge and calls send.
*/
`timescale 1ns/1ps
module ufc_remote #(
  parameter int TICK = 16
)(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       cts_hold,
  output logic            bit_tick,
  output logic            rx_valid,
  output logic [7:0]      rx_char,
  output logic            cts_n
);
  int cnt;

  // free running bit time tick
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cnt      <= 0;
      bit_tick <= 1'b0;
    end
    else
    begin
      cnt      <= (cnt == TICK - 1) ? 0 : cnt + 1;
      bit_tick <= (cnt == TICK - 1);
    end

  always_ff @(posedge pclk)
    cts_n <= cts_hold;

  // idle receive lines
  initial
  begin
    rx_valid = 1'b0;
    rx_char  = 8'h00;
  end

  // one character per pulse, pairs sent as two calls
  task automatic send(input logic [7:0] c);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_char  <= c;
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_char  <= ~c;  // stale data never repeats the last character
  endtask
endmodule

// *** uart_flow_control_features_tb_top.sv ***
/*
  self-checking bench of the uart flow control feature block.
  assumes the remote model for tick, characters and cts; apb master here.
*/
`timescale 1ns/1ps
module uart_flow_control_features_tb_top;
  import ufc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, rx_char, rx_trigger_level, tx_trigger_level, r;
  logic [31:0] pwdata, prdata, seed;
  logic        thr_empty, tsr_empty, tx_fifo_write, bit_tick, rx_valid;
  logic        rx_at_trigger, rx_above_upper, rx_below_lower, cts_n;
  logic        cts_hold, rts_n, tx_int, tx_go, rx_store, rx_resume;
  logic        rx_stop, special_int, rx_trig_int;
  logic [6:0]  rx_count, tx_count;
  logic [1:0]  table_sel, tx_flow_sel;
  logic [8:0]  rq[$];
  logic [8:0]  e_q;
  int          error_cnt, compares;

  ufc_features #(.CNT_W(7)) u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .thr_empty, .tsr_empty, .tx_fifo_write, .bit_tick,
    .rx_count, .tx_count, .rx_at_trigger, .rx_above_upper,
    .rx_below_lower, .rx_valid, .rx_char, .cts_n, .rts_n, .tx_int, .tx_go,
    .rx_store, .rx_resume, .rx_stop, .special_int, .rx_trig_int,
    .table_sel, .tx_flow_sel, .rx_trigger_level, .tx_trigger_level);

  ufc_remote #(.TICK(16)) u_far (
    .pclk, .presetn, .cts_hold, .bit_tick, .rx_valid, .rx_char, .cts_n);

  // 50 MHz clock
  initial pclk = 1'b0;
  always #10 pclk = ~pclk;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  // one apb transfer; a read notes its expected data and error flag
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h00_0000, d};
    if (!w)
      rq.push_back({a > OFS_COUNT, d});
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);  // only the hang guard ends a stuck wait
    psel    <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  // read results compared with the oldest note
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite)
    begin
      e_q = rq.pop_front();
      check("prdata", prdata, {24'h00_0000, e_q[7:0]});
      check("pslverr", pslverr, e_q[8]);
    end

  task automatic txs(input logic thr, tsr);
    @(posedge pclk);
    thr_empty <= thr;
    tsr_empty <= tsr;
    cyc(1);
  endtask

  task automatic lv(input logic [2:0] v);
    @(posedge pclk);
    {rx_at_trigger, rx_above_upper, rx_below_lower} <= v;
    cyc(2);
  endtask

  // flags order: store, stop, special, resume
  task automatic rx(input logic [7:0] c, input logic [3:0] m, e);
    fork
      u_far.send(c);
      begin
        cyc(1);
        check("rx flags", {rx_store, rx_stop, special_int, rx_resume} & m, e);
      end
    join
  endtask

  // one direction-controlled character from fifo write to idle
  task automatic dir_run(input logic inv);
    @(posedge pclk);
    tx_fifo_write <= 1'b1;
    thr_empty     <= 1'b0;
    tsr_empty     <= 1'b0;
    @(posedge pclk);
    tx_fifo_write <= 1'b0;
    #1;
    check("rts_n send", rts_n, inv);
    txs(1, 0);
    check("tx_int held", tx_int, 0);
    @(posedge pclk iff bit_tick);
    tsr_empty <= 1'b1;
    cyc(1);
    check("rts_n tail", rts_n, inv);
    check("tx_int", tx_int, 1);
    @(posedge pclk iff bit_tick);
    #1;
    check("rts_n idle", rts_n, !inv);
  endtask

  // hang guard
  initial
  begin
    #400_000;
    error_cnt++;
    end_of_test();
  end

  // main sequence
  initial
  begin
    seed = 32'h0000_7d43;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {thr_empty, tsr_empty, tx_fifo_write, cts_hold} = 4'b1100;
    {rx_at_trigger, rx_above_upper, rx_below_lower} = 3'b000;
    rx_count = 7'(xs());
    tx_count = 7'(xs());
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, OFS_FEATURE, RST_ZERO);
    apb(0, OFS_SCRATCH, RST_SCRATCH);
    apb(0, OFS_INT_EN, RST_ZERO);
    apb(0, 8'h3C, 8'h00);
    apb(1, OFS_INT_EN, 8'hFF);
    apb(0, OFS_INT_EN, 8'h0F);
    apb(1, OFS_MODEM, 8'hFF);
    apb(0, OFS_MODEM, 8'h1F);
    apb(1, OFS_ENHANCED, 8'h10);
    apb(1, OFS_FIFO_CTL, 8'h30);
    apb(1, OFS_ENHANCED, 8'h00);
    apb(1, OFS_FIFO_CTL, 8'h00);
    apb(0, OFS_FIFO_CTL, 8'h30);
    apb(1, OFS_MODEM, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      apb(1, OFS_FEATURE, 8'(i << FC_TBL_LO));
      check("table_sel", table_sel, 32'(i));
      apb(1, OFS_ENHANCED, 8'h00);
      apb(1, OFS_ENHANCED, 8'(i << 2));
      check("tx_flow_sel", tx_flow_sel, 32'(i));
    end
    r = 8'(xs());
    apb(1, OFS_SCRATCH, r);
    apb(0, OFS_SCRATCH, r);
    apb(1, OFS_FEATURE, 8'h40);
    apb(1, OFS_SCRATCH, 8'h81);
    apb(0, OFS_SCRATCH, {1'b0, tx_count});
    apb(1, OFS_SCRATCH, RST_MODE);
    apb(0, OFS_SCRATCH, {1'b0, rx_count});
    apb(1, OFS_SCRATCH, 8'h83);
    apb(0, OFS_SCRATCH, {1'b0, rx_count});
    apb(0, OFS_SCRATCH, {1'b0, tx_count});
    apb(0, OFS_SCRATCH, {1'b0, rx_count});
    apb(1, OFS_SCRATCH, RST_MODE);
    apb(1, OFS_FEATURE, 8'h00);
    apb(0, OFS_SCRATCH, r);
    apb(0, OFS_COUNT, {1'b0, rx_count});
    apb(1, OFS_TRIGGER, 8'h21);
    check("rx_trigger_level", rx_trigger_level, 8'h21);
    apb(1, OFS_FEATURE, 8'h80);
    apb(0, OFS_COUNT, {1'b0, tx_count});
    apb(1, OFS_TRIGGER, 8'h12);
    check("tx_trigger_level", tx_trigger_level, 8'h12);
    apb(1, OFS_FEATURE, 8'h00);
    txs(1, 0);
    check("tx_int legacy", tx_int, 1);
    txs(1, 1);
    apb(1, OFS_FEATURE, 8'h08);
    dir_run(1'b0);
    apb(1, OFS_FEATURE, 8'h48);
    apb(1, OFS_SCRATCH, 8'h88);
    dir_run(1'b1);
    apb(1, OFS_SCRATCH, RST_MODE);
    apb(1, OFS_FEATURE, 8'h00);
    apb(1, OFS_STOP2, 8'hA5);
    apb(1, OFS_ENHANCED, 8'h30);
    rx(8'hA5, 4'b1100, 4'b1000);
    apb(0, OFS_INT_STAT, 8'h10);
    apb(1, OFS_INT_EN, 8'h20);
    apb(1, OFS_ENHANCED, 8'h00);
    apb(1, OFS_ENHANCED, 8'h31);
    rx(8'hA5, 4'b1110, 4'b0110);
    apb(1, OFS_STOP1, 8'h44);
    apb(1, OFS_RESUME1, 8'h11);
    apb(1, OFS_RESUME2, 8'h22);
    apb(1, OFS_ENHANCED, 8'h00);
    apb(1, OFS_ENHANCED, 8'h02);
    rx(8'h44, 4'b0100, 4'b0100);
    apb(1, OFS_ENHANCED, 8'h00);
    apb(1, OFS_ENHANCED, 8'h0B);
    rx(8'h22, 4'b0001, 4'b0001);
    apb(1, OFS_ENHANCED, 8'h00);
    apb(1, OFS_ENHANCED, 8'h0F);
    rx(8'h11, 4'b0001, 4'b0000);
    rx(8'h22, 4'b0001, 4'b0001);
    apb(1, OFS_ENHANCED, 8'h00);
    apb(1, OFS_ENHANCED, 8'h80);
    txs(0, 0);
    @(posedge pclk);
    cts_hold <= 1'b1;
    cyc(6);
    check("tx_go busy", tx_go, 1);
    txs(1, 1);
    cyc(4);
    check("tx_go stop", tx_go, 0);
    @(posedge pclk);
    cts_hold <= 1'b0;
    cyc(6);
    check("tx_go go", tx_go, 1);
    apb(1, OFS_ENHANCED, 8'h00);
    apb(1, OFS_ENHANCED, 8'h40);
    lv(3'b001);
    check("rts_n refused", rts_n, 1);
    apb(1, OFS_MODEM, 8'h02);
    cyc(1);
    check("rts_n on", rts_n, 0);
    lv(3'b110);
    check("rts_n full", rts_n, 1);
    check("rx_trig_int", rx_trig_int, 1);
    lv(3'b001);
    check("rts_n drain", rts_n, 0);
    apb(1, OFS_ENHANCED, 8'h00);
    lv(3'b110);
    check("rts_n gpio", rts_n, 0);
    apb(1, OFS_MODEM, 8'h00);
    cyc(1);
    check("rts_n gpio", rts_n, 1);
    cyc(2);
    end_of_test();
  end
endmodule
